// ==== pfs_sequencer.sv ====
/*
 * Flash erase and write sequencer with unlock keys, write latches,
 * auxiliary space selection and completion flag, on classic Wishbone.
 * Assumes single-cycle flash read data and same-clock control inputs.
 */
// Functional notes
// - Arm by key 55h, then key AAh, then write_initiate, in that order.
// - Act only on an unbroken sequence; an abort cancels it and sets the write error flag.
// - Erase, commit and latch load all need the unlock sequence.
// - Stall the processor until the erase or write has finished.
// - Erase only whole rows; writing never erases implicitly.
// - A protected address clears write_initiate and skips an erase or commit; a latch-only load still loads.
// - Erase completion sets the done flag; interrupt only when enabled.
// - Erase leaves latch contents and write_enable_gate unchanged.
// - Upper eleven address bits pick the row, lowest five the latch.
// - Every completed write returns all latches to blank 3FFFh.
// - With latch_only_load set, unlock only loads the addressed latch.
// - With latch_only_load clear, load the last word and program the row.
// - One programming operation writes at most thirty-two words.
// - Partial rows allowed; unloaded latches program as blank.
// - config_space_select maps accesses to the space with bit 15 set.
// - Reads outside valid auxiliary ranges clear the data pair to zero.
// - Write error flag on protected write, reset mid-write, broken unlock.
// - A row is thirty-two fourteen-bit words, the smallest erase unit.
// - read_initiate fetches the word next cycle, then clears itself.
`timescale 1ns/1ps
`include "pfs_defs.svh"

module pfs_sequencer (
  input  wire logic        clk_sys,     // System clock, 100 MHz.
  input  wire logic        rst,         // Synchronous reset, active high.
  input  wire logic        wb_cyc_i,    // Wishbone cycle.
  input  wire logic        wb_stb_i,    // Wishbone strobe.
  input  wire logic        wb_we_i,     // Wishbone write.
  input  wire logic [7:0]  wb_adr_i,    // Wishbone byte address.
  input  wire logic [3:0]  wb_sel_i,    // Wishbone byte enables.
  input  wire logic [31:0] wb_dat_i,    // Wishbone write data.
  output logic      [31:0] wb_dat_o,    // Wishbone read data.
  output logic             wb_ack_o,    // Wishbone acknowledge.
  input  wire logic        seq_abort,   // Interrupt or halt hit the CPU.
  input  wire logic        write_protect, // Program space write-protected.
  output logic             flash_rd_en, // Flash read strobe.
  output logic             flash_erase, // Flash row erase strobe.
  output logic             flash_prog,  // Flash word program strobe.
  output logic      [15:0] flash_addr,  // Flash word address.
  output logic      [13:0] flash_wdata, // Flash program data.
  input  wire logic [13:0] flash_rdata, // Flash read data, one cycle late.
  output logic             cpu_stall,   // Processor stall.
  output logic             nvm_irq      // Completion interrupt.
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations.

  pfs_pkg::pfs_state_t state_q, state_d;
  pfs_pkg::pfs_key_t   key_q;
  logic        rd_q, wr_q, write_enable_gate_q, werr_q, latch_only_load_q, free_q, regs_q;
  logic [7:0]  adr_lo_q, dat_lo_q;
  logic [6:0]  adr_hi_q;
  logic [5:0]  dat_hi_q;
  logic        done_q, ie_q;
  logic [4:0]  idx_q, idx_d;
  logic [15:0] addr16;
  logic [13:0] lat_rdata;
  logic        acc, wr_acc, ctrl_wr, key_wr;
  logic [7:0]  wbyte;
  logic        go, go_bad, go_erase, go_load, go_prog, rd_go;
  logic        done_set, tmr_done, tmr_start, lat_clr, op_end;
  logic [15:0] tmr_cycles;

  // Program space has bit 15 clear and ends at 3FFFh.
  function automatic logic in_pfm(input logic [15:0] a);
    return !a[15] && !a[14];
  endfunction : in_pfm

  // Auxiliary words that accept self-writes: user IDs and config words.
  function automatic logic aux_wr_ok(input logic [15:0] a);
    return (a >= 16'h8000 && a <= 16'h8003) ||
           (a >= 16'h8007 && a <= 16'h800B);
  endfunction : aux_wr_ok

  // Auxiliary words that hold readable data.
  function automatic logic aux_rd_ok(input logic [15:0] a);
    return aux_wr_ok(a) || (a >= 16'h8005 && a <= 16'h8006) ||
           (a >= 16'h8100 && a <= 16'h82FF);
  endfunction : aux_rd_ok

  ////////////////////////////////////////////////////////////////////////
  // Bus decode.

  // A request is taken in its first cycle; ack follows one cycle later.
  assign acc     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_acc  = acc && wb_we_i && wb_sel_i[0];
  assign wbyte   = wb_dat_i[7:0];
  assign ctrl_wr = wr_acc && wb_adr_i == `PFS_OFS_CTRL;
  assign key_wr  = wr_acc && wb_adr_i == `PFS_OFS_KEY;
  assign addr16  = {regs_q, adr_hi_q, adr_lo_q};

  // Start of a write action: armed keys, gate set, sequencer free.
  assign go = ctrl_wr && wbyte[`PFS_B_WR] && wbyte[`PFS_B_WRITE_ENABLE_GATE] &&
              key_q == pfs_pkg::KEY_TWO && !seq_abort &&
              state_q == pfs_pkg::ST_IDLE;
  // Protected or read-only targets refuse erase and commit.
  assign go_bad = (in_pfm(addr16) && write_protect) ||
                  !(in_pfm(addr16) || aux_wr_ok(addr16));
  assign go_erase = go && wbyte[`PFS_B_FREE] && !go_bad;
  assign go_load  = go && !wbyte[`PFS_B_FREE] &&
                    (wbyte[`PFS_B_LATCH_ONLY_LOAD] || !go_bad);
  assign go_prog  = go_load && !wbyte[`PFS_B_LATCH_ONLY_LOAD];
  assign rd_go    = ctrl_wr && wbyte[`PFS_B_RD] && !go &&
                    state_q == pfs_pkg::ST_IDLE;
  assign op_end   = tmr_done && (state_q == pfs_pkg::ST_EWAIT ||
                    (state_q == pfs_pkg::ST_PWAIT && idx_q == `PFS_LAST_IDX));
  assign done_set = op_end;
  assign lat_clr  = op_end && state_q == pfs_pkg::ST_PWAIT;

  ////////////////////////////////////////////////////////////////////////
  // Bus slave.

  // Acknowledge every request once and return registered read data.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= 32'h0000_0000;
      if (acc && !wb_we_i) begin
        unique case (wb_adr_i)
          `PFS_OFS_CTRL:   wb_dat_o[6:0] <= {regs_q, free_q, latch_only_load_q, werr_q,
                                             write_enable_gate_q, wr_q, rd_q};
          `PFS_OFS_ADR_LO: wb_dat_o[7:0] <= adr_lo_q;
          `PFS_OFS_ADR_HI: wb_dat_o[6:0] <= adr_hi_q;
          `PFS_OFS_DAT_LO: wb_dat_o[7:0] <= dat_lo_q;
          `PFS_OFS_DAT_HI: wb_dat_o[5:0] <= dat_hi_q;
          `PFS_OFS_STATUS: wb_dat_o[1:0] <= {ie_q, done_q};
          default:         wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Unlock key detector.

  // Track 55h then AAh; any other write or an abort restarts detection.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      key_q <= pfs_pkg::KEY_IDLE;
    end else if (seq_abort) begin
      key_q <= pfs_pkg::KEY_IDLE;
    end else if (key_wr) begin
      unique case (key_q)
        pfs_pkg::KEY_IDLE: key_q <= (wbyte == `PFS_KEY1) ?
                                    pfs_pkg::KEY_ONE : pfs_pkg::KEY_IDLE;
        pfs_pkg::KEY_ONE:  key_q <= (wbyte == `PFS_KEY2) ?
                                    pfs_pkg::KEY_TWO : pfs_pkg::KEY_IDLE;
        pfs_pkg::KEY_TWO:  key_q <= pfs_pkg::KEY_IDLE;
        default:           key_q <= pfs_pkg::KEY_IDLE;
      endcase
    end else if (wr_acc) begin
      key_q <= pfs_pkg::KEY_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register.

  // Software bits follow writes made while idle; hardware clears rd and wr on completion.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_q   <= 1'b0;
      wr_q   <= 1'b0;
      write_enable_gate_q <= 1'b0;
      latch_only_load_q <= 1'b0;
      free_q <= 1'b0;
      regs_q <= 1'b0;
    end else begin
      if (ctrl_wr && state_q == pfs_pkg::ST_IDLE) begin
        write_enable_gate_q <= wbyte[`PFS_B_WRITE_ENABLE_GATE];
        latch_only_load_q <= wbyte[`PFS_B_LATCH_ONLY_LOAD];
        free_q <= wbyte[`PFS_B_FREE];
        regs_q <= wbyte[`PFS_B_REGS];
      end
      if (rd_go) begin
        rd_q <= 1'b1;
      end else if (state_q == pfs_pkg::ST_RDCAP) begin
        rd_q <= 1'b0;
      end
      if (go_erase || go_prog) begin
        wr_q <= 1'b1;
      end else if (op_end) begin
        wr_q <= 1'b0;
      end
    end
  end

  // Error flag: a reset during a running write leaves it set.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      werr_q <= wr_q;
    end else if ((seq_abort && key_q != pfs_pkg::KEY_IDLE) ||
                 (go && !go_erase && !go_load)) begin
      werr_q <= 1'b1;
    end else if (ctrl_wr) begin
      werr_q <= wbyte[`PFS_B_WERR];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address, data and status registers.

  // Read capture wins over software writes to the data pair.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      adr_lo_q <= 8'h00;
      adr_hi_q <= 7'h00;
      dat_lo_q <= 8'h00;
      dat_hi_q <= 6'h00;
    end else begin
      if (wr_acc && wb_adr_i == `PFS_OFS_ADR_LO) adr_lo_q <= wbyte;
      if (wr_acc && wb_adr_i == `PFS_OFS_ADR_HI) adr_hi_q <= wbyte[6:0];
      if (state_q == pfs_pkg::ST_RDCAP) begin
        if (in_pfm(addr16) || aux_rd_ok(addr16)) begin
          {dat_hi_q, dat_lo_q} <= flash_rdata;
        end else begin
          {dat_hi_q, dat_lo_q} <= 14'h0000;
        end
      end else begin
        if (wr_acc && wb_adr_i == `PFS_OFS_DAT_LO) dat_lo_q <= wbyte;
        if (wr_acc && wb_adr_i == `PFS_OFS_DAT_HI) dat_hi_q <= wbyte[5:0];
      end
    end
  end

  // Done flag: hardware set wins over a software clear in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      done_q <= 1'b0;
      ie_q   <= 1'b0;
    end else begin
      if (done_set) begin
        done_q <= 1'b1;
      end else if (wr_acc && wb_adr_i == `PFS_OFS_STATUS) begin
        done_q <= wbyte[`PFS_B_DONE];
      end
      if (wr_acc && wb_adr_i == `PFS_OFS_STATUS) ie_q <= wbyte[`PFS_B_IE];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Operation sequencer.

  // Next state and latch index for read, erase and row programming.
  always_comb begin
    state_d = state_q;
    idx_d   = idx_q;
    unique case (state_q)
      pfs_pkg::ST_IDLE: begin
        idx_d = 5'h00;
        if (go_erase) state_d = pfs_pkg::ST_ERASE;
        else if (go_prog) state_d = pfs_pkg::ST_PROG;
        else if (rd_go) state_d = pfs_pkg::ST_RD;
      end
      pfs_pkg::ST_RD:    state_d = pfs_pkg::ST_RDCAP;
      pfs_pkg::ST_RDCAP: state_d = pfs_pkg::ST_IDLE;
      pfs_pkg::ST_ERASE: state_d = pfs_pkg::ST_EWAIT;
      pfs_pkg::ST_EWAIT: if (tmr_done) state_d = pfs_pkg::ST_IDLE;
      pfs_pkg::ST_PROG:  state_d = pfs_pkg::ST_PWAIT;
      pfs_pkg::ST_PWAIT: begin
        if (tmr_done) begin
          if (idx_q == `PFS_LAST_IDX) begin
            state_d = pfs_pkg::ST_IDLE;
          end else begin
            state_d = pfs_pkg::ST_PROG;
            idx_d   = idx_q + 5'h01;
          end
        end
      end
    endcase
  end

  // State and index registers.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= pfs_pkg::ST_IDLE;
      idx_q   <= 5'h00;
    end else begin
      state_q <= state_d;
      idx_q   <= idx_d;
    end
  end

  // Flash strobes, address and data, registered from the next state.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flash_rd_en <= 1'b0;
      flash_erase <= 1'b0;
      flash_prog  <= 1'b0;
      flash_addr  <= 16'h0000;
      flash_wdata <= `PFS_BLANK;
      cpu_stall   <= 1'b0;
      nvm_irq     <= 1'b0;
    end else begin
      flash_rd_en <= state_d == pfs_pkg::ST_RD;
      flash_erase <= state_d == pfs_pkg::ST_ERASE;
      flash_prog  <= state_d == pfs_pkg::ST_PROG;
      flash_addr  <= (state_d == pfs_pkg::ST_PROG) ?
                     {addr16[15:5], idx_d} : {addr16[15:5], 5'h00};
      // The read address takes the space bit written with read_initiate.
      if (state_d == pfs_pkg::ST_RD) begin
        flash_addr <= {wbyte[`PFS_B_REGS], adr_hi_q, adr_lo_q};
      end
      // The final word bypasses its latch, which loads at this same edge.
      flash_wdata <= (go_load && adr_lo_q[4:0] == idx_d) ?
                     {dat_hi_q, dat_lo_q} : lat_rdata;
      cpu_stall   <= state_d != pfs_pkg::ST_IDLE;
      nvm_irq     <= (done_q || done_set) && ie_q;
    end
  end

  assign tmr_start  = state_q == pfs_pkg::ST_ERASE ||
                      state_q == pfs_pkg::ST_PROG;
  assign tmr_cycles = (state_q == pfs_pkg::ST_ERASE) ?
                      16'(`PFS_ERASE_CYC) : 16'(`PFS_WORD_CYC);

  // Programming timer for erase and per-word write times.
  pfs_op_timer u_timer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (tmr_start),
    .cycles  (tmr_cycles),
    .done    (tmr_done)
  );

  // Write latches: loaded by every armed latch load and by each commit that is not refused.
  pfs_latch_bank u_latch (
    .clk_sys (clk_sys),
    .rst     (rst),
    .we      (go_load),
    .widx    (adr_lo_q[4:0]),
    .wdata   ({dat_hi_q, dat_lo_q}),
    .clr     (lat_clr),
    .ridx    (idx_d),
    .rdata   (lat_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic [5:0] prog_cnt_q;

  // Counts program strobes within one row operation.
  always_ff @(posedge clk_sys) begin
    if (rst || state_q == pfs_pkg::ST_IDLE) prog_cnt_q <= 6'h00;
    else if (flash_prog) prog_cnt_q <= prog_cnt_q + 6'h01;
  end

  a_erase_needs_keys: assert property ($rose(flash_erase) |->
    $past(key_q) == pfs_pkg::KEY_TWO && $past(write_enable_gate_q | go))
    else $error("erase started without unlock");
  a_abort_cancels: assert property (
    seq_abort && key_q != pfs_pkg::KEY_IDLE && !ctrl_wr |=>
    key_q == pfs_pkg::KEY_IDLE && werr_q && state_q == pfs_pkg::ST_IDLE)
    else $error("abort did not cancel unlock");
  a_stall_busy: assert property (
    state_q != pfs_pkg::ST_IDLE |-> cpu_stall)
    else $error("processor not stalled while busy");
  a_protect_blocks: assert property (
    go && wbyte[`PFS_B_FREE] && write_protect && in_pfm(addr16) |=>
    !wr_q && werr_q ##1 !flash_erase)
    else $error("protected erase not refused");
  a_done_irq: assert property (
    state_q == pfs_pkg::ST_EWAIT && tmr_done |=> done_q ##0 nvm_irq == ie_q)
    else $error("done flag or interrupt wrong after erase");
  a_row_words: assert property (
    op_end && state_q == pfs_pkg::ST_PWAIT |-> prog_cnt_q == 6'h20)
    else $error("row write did not program 32 words");
  a_load_only: assert property (
    go_load && wbyte[`PFS_B_LATCH_ONLY_LOAD] |=> !flash_prog && !flash_erase && !wr_q)
    else $error("latch load started programming");
  a_read_clears: assert property (
    rd_go |=> flash_rd_en ##2 !rd_q && !cpu_stall)
    else $error("read did not complete in time");
  a_key_restart: assert property (
    key_wr && key_q == pfs_pkg::KEY_ONE && wbyte != `PFS_KEY2 && !seq_abort
    |=> key_q == pfs_pkg::KEY_IDLE)
    else $error("broken key order not restarted");

  c_erase_done: cover property (state_q == pfs_pkg::ST_EWAIT && tmr_done);
  c_row_done:   cover property (lat_clr);
  c_latch_load: cover property (go_load && wbyte[`PFS_B_LATCH_ONLY_LOAD]);
  c_aux_zero:   cover property (state_q == pfs_pkg::ST_RDCAP && regs_q &&
                                !aux_rd_ok(addr16));

endmodule : pfs_sequencer

// ==== pfs_defs.svh ====
/*
 * Constants of the flash erase and write sequencer: register offsets,
 * control bit positions, unlock keys, reset values and timing counts.
 * Assumes a 100 MHz system clock and a 32-bit classic Wishbone bus.
 */
`ifndef PFS_DEFS_SVH
`define PFS_DEFS_SVH

// Register byte offsets, one aligned word each.
`define PFS_OFS_CTRL    8'h00
`define PFS_OFS_KEY     8'h04
`define PFS_OFS_ADR_LO  8'h08
`define PFS_OFS_ADR_HI  8'h0C
`define PFS_OFS_DAT_LO  8'h10
`define PFS_OFS_DAT_HI  8'h14
`define PFS_OFS_STATUS  8'h18

// Bit positions in the control register.
`define PFS_B_RD    0
`define PFS_B_WR    1
`define PFS_B_WRITE_ENABLE_GATE  2
`define PFS_B_WERR  3
`define PFS_B_LATCH_ONLY_LOAD  4
`define PFS_B_FREE  5
`define PFS_B_REGS  6

// Bit positions in the status register.
`define PFS_B_DONE  0
`define PFS_B_IE    1

// Unlock keys and blank latch value.
`define PFS_KEY1    8'h55
`define PFS_KEY2    8'hAA
`define PFS_BLANK   14'h3FFF
`define PFS_LAST_IDX 5'h1F

// Timing: clock period and operation times in ns, counts rounded up.
`define PFS_CLK_NS      10
`define PFS_T_ERASE_NS  20000
`define PFS_T_WORD_NS   2500
`define PFS_ERASE_CYC   ((`PFS_T_ERASE_NS + `PFS_CLK_NS - 1) / `PFS_CLK_NS)
`define PFS_WORD_CYC    ((`PFS_T_WORD_NS + `PFS_CLK_NS - 1) / `PFS_CLK_NS)

`endif

// ==== pfs_pkg.sv ====
/*
 * Types of the flash erase and write sequencer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pfs_pkg;

  // Operation sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE, ST_RD, ST_RDCAP, ST_ERASE, ST_EWAIT, ST_PROG, ST_PWAIT
  } pfs_state_t;

  // Unlock key detector states.
  typedef enum logic [1:0] {
    KEY_IDLE, KEY_ONE, KEY_TWO
  } pfs_key_t;

endpackage : pfs_pkg

// ==== pfs_op_timer.sv ====
/*
 * Programming timer: counts a loaded number of cycles and pulses done.
 * Assumes a synchronous active-high reset on the system clock.
 */
`timescale 1ns/1ps

module pfs_op_timer (
  input  wire logic        clk_sys, // System clock.
  input  wire logic        rst,     // Synchronous reset, active high.
  input  wire logic        start,   // Load pulse.
  input  wire logic [15:0] cycles,  // Cycles until done, at least one.
  output logic             done     // One-cycle pulse at expiry.
);

  logic [15:0] cnt_q;
  logic        run_q;

  // Count down after a start and pulse done when the count runs out.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_q <= 16'h0000;
      run_q <= 1'b0;
      done  <= 1'b0;
    end else if (start) begin
      cnt_q <= cycles;
      run_q <= 1'b1;
      done  <= 1'b0;
    end else if (run_q && cnt_q <= 16'h0001) begin
      run_q <= 1'b0;
      done  <= 1'b1;
    end else begin
      cnt_q <= run_q ? cnt_q - 16'h0001 : cnt_q;
      done  <= 1'b0;
    end
  end

endmodule : pfs_op_timer

// ==== pfs_latch_bank.sv ====
/*
 * Bank of 32 write latches of 14 bits for one flash row.
 * Assumes a synchronous active-high reset on the system clock.
 */
`timescale 1ns/1ps
`include "pfs_defs.svh"

module pfs_latch_bank (
  input  wire logic        clk_sys, // System clock.
  input  wire logic        rst,     // Synchronous reset, active high.
  input  wire logic        we,      // Load one latch.
  input  wire logic [4:0]  widx,    // Latch to load.
  input  wire logic [13:0] wdata,   // Word to load.
  input  wire logic        clr,     // Return every latch to blank.
  input  wire logic [4:0]  ridx,    // Latch to read.
  output logic      [13:0] rdata    // Word read, combinational.
);

  logic [13:0] mem_q [32];

  // Load one latch, or blank them all; blanking takes priority.
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 32; i++) begin
      if (rst || clr) begin
        mem_q[i] <= `PFS_BLANK;
      end else if (we && widx == 5'(i)) begin
        mem_q[i] <= wdata;
      end
    end
  end

  assign rdata = mem_q[ridx];

  // A blanking pulse leaves the first and last latch blank.
  a_latch_blanked: assert property (@(posedge clk_sys) disable iff (rst)
    clr |=> mem_q[0] == `PFS_BLANK && mem_q[31] == `PFS_BLANK)
    else $error("write latches not blank after clear");

endmodule : pfs_latch_bank

// ==== pfs_flash_model.sv ====
/* Flash array model: 256 words, row erase, program-to-zero, word read.
   Assumes one-cycle strobes from the sequencer on clk_sys. */
`timescale 1ns/1ps

module pfs_flash_model (
  input  wire logic        clk_sys, // System clock.
  input  wire logic        rd_en,   // Read strobe.
  input  wire logic        erase,   // Row erase strobe.
  input  wire logic        prog,    // Word program strobe.
  input  wire logic [15:0] addr,    // Word address.
  input  wire logic [13:0] wdata,   // Program data.
  output logic      [13:0] rdata    // Read data, valid one cycle.
);
  logic [13:0] mem [0:255];

  ////////////////////////////////////////////////////////////
  // The array starts programmed to zero so a skipped erase shows.
  initial begin
    foreach (mem[i]) mem[i] = 14'h0000;
    rdata = 14'h0000;
  end

  // Erase blanks a whole row; programming only clears bits.
  always @(posedge clk_sys) begin
    if (erase)
      for (int i = 0; i < 32; i++) mem[{addr[7:5], 5'(i)}] = 14'h3FFF;
    if (prog) mem[addr[7:0]] = mem[addr[7:0]] & wdata;
    if (rd_en) rdata <= mem[addr[7:0]];
    else rdata <= ~rdata; // Stale data is scrambled, never held.
  end
endmodule : pfs_flash_model

// ==== pfs_sequencer_tb.sv ====
/* Bench of the flash sequencer: Wishbone tasks and register scenarios.
   Assumes the offsets and keys of pfs_defs.svh and a flash model. */
`timescale 1ns/1ps
`include "pfs_defs.svh"

module pfs_sequencer_tb;
  logic        clk_sys = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0;
  logic        we = 1'b0, abrt = 1'b0, wp = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdo, rdat;
  logic        ack, f_rd, f_er, f_pg, stall, irq;
  logic [15:0] f_ad;
  logic [13:0] f_wd, f_rdat;
  int          error_cnt = 0, num_checks = 0, ners = 0, nprg = 0;

  pfs_sequencer pfs_sequencer_i (.clk_sys(clk_sys), .rst(rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdo), .wb_ack_o(ack),
    .seq_abort(abrt), .write_protect(wp), .flash_rd_en(f_rd),
    .flash_erase(f_er), .flash_prog(f_pg), .flash_addr(f_ad),
    .flash_wdata(f_wd), .flash_rdata(f_rdat), .cpu_stall(stall),
    .nvm_irq(irq));
  pfs_flash_model pfs_flash_model_i (.clk_sys(clk_sys), .rd_en(f_rd),
    .erase(f_er), .prog(f_pg), .addr(f_ad), .wdata(f_wd), .rdata(f_rdat));

  ////////////////////////////////////////////////////////////
  // Clock and flash strobe counters.
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (f_er === 1'b1) ners++;
    if (f_pg === 1'b1) nprg++;
  end

  task automatic end_of_test;
    if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      $display("[ERR] %s exp %h got %h", nm, e, s);
      error_cnt++;
    end
  endtask : chk

  // One classic cycle; the request holds until ack is sampled.
  task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = rdo;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      error_cnt++;
      end_of_test();
    end
  endtask : bus

  task automatic rd(logic [7:0] a, logic [31:0] e, string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, e, rdat);
  endtask : rd

  task automatic idle;
    int n;
    n = 0;
    @(posedge clk_sys);
    while (stall !== 1'b0 && n < 9000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 9000) begin
      error_cnt++;
      end_of_test();
    end
  endtask : idle

  // Keys, then initiate, with interrupts assumed off around it.
  task automatic arm(logic [7:0] c);
    bus(1'b1, `PFS_OFS_KEY, `PFS_KEY1);
    bus(1'b1, `PFS_OFS_KEY, `PFS_KEY2);
    bus(1'b1, `PFS_OFS_CTRL, c);
    idle();
  endtask : arm

  task automatic rword(logic [7:0] lo, logic [13:0] e);
    bus(1'b1, `PFS_OFS_ADR_LO, lo);
    bus(1'b1, `PFS_OFS_CTRL, 8'h01);
    idle();
    rd(`PFS_OFS_DAT_LO, {24'h0, e[7:0]}, "dat_lo");
    rd(`PFS_OFS_DAT_HI, {26'h0, e[13:8]}, "dat_hi");
  endtask : rword

  ////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`PFS_OFS_CTRL, 32'h0, "ctrl_rst");
    rd(`PFS_OFS_STATUS, 32'h0, "stat_rst");
    bus(1'b1, `PFS_OFS_STATUS, 8'h02);
    bus(1'b1, `PFS_OFS_ADR_LO, 8'h25);
    bus(1'b1, `PFS_OFS_KEY, `PFS_KEY1);
    bus(1'b1, `PFS_OFS_KEY, 8'h5A);
    bus(1'b1, `PFS_OFS_KEY, `PFS_KEY2);
    bus(1'b1, `PFS_OFS_CTRL, 8'h26);
    idle();
    chk("erase_cnt", 32'h0, ners);
    bus(1'b1, `PFS_OFS_KEY, `PFS_KEY1);
    bus(1'b1, `PFS_OFS_KEY, `PFS_KEY2);
    abrt <= 1'b1;
    @(posedge clk_sys);
    abrt <= 1'b0;
    rd(`PFS_OFS_CTRL, 32'h2C, "ctrl_abort");
    bus(1'b1, `PFS_OFS_CTRL, 8'h26);
    chk("erase_cnt", 32'h0, ners);
    bus(1'b1, `PFS_OFS_CTRL, 8'h24);
    arm(8'h26);
    chk("erase_cnt", 32'd1, ners);
    rd(`PFS_OFS_CTRL, 32'h24, "ctrl_erase");
    rd(`PFS_OFS_STATUS, 32'h03, "stat_done");
    chk("irq", 32'd1, {31'h0, irq});
    bus(1'b1, `PFS_OFS_ADR_LO, 8'h23);
    bus(1'b1, `PFS_OFS_DAT_LO, 8'h34);
    bus(1'b1, `PFS_OFS_DAT_HI, 8'h12);
    arm(8'h16);
    chk("prog_cnt", 32'd0, nprg);
    bus(1'b1, `PFS_OFS_ADR_LO, 8'h24);
    bus(1'b1, `PFS_OFS_DAT_LO, 8'h67);
    bus(1'b1, `PFS_OFS_DAT_HI, 8'h05);
    arm(8'h06);
    chk("prog_cnt", 32'd32, nprg);
    rword(8'h05, 14'h0000);
    rword(8'h23, 14'h1234);
    rword(8'h24, 14'h0567);
    rword(8'h25, 14'h3FFF);
    wp <= 1'b1;
    arm(8'h26);
    wp <= 1'b0;
    chk("erase_cnt", 32'd1, ners);
    rd(`PFS_OFS_CTRL, 32'h2C, "ctrl_wp");
    bus(1'b1, `PFS_OFS_ADR_LO, 8'h25);
    bus(1'b1, `PFS_OFS_CTRL, 8'h41);
    idle();
    chk("aux_sel", 32'd1, {31'h0, f_ad[15]});
    rd(`PFS_OFS_DAT_LO, 32'h0, "aux_dat");
    rd(`PFS_OFS_DAT_HI, 32'h0, "aux_dat_hi");
    rd(8'h1C, 32'h0, "unmapped");
    // A one-cycle reset in mid erase must leave the error flag set.
    bus(1'b1, `PFS_OFS_CTRL, 8'h04);
    bus(1'b1, `PFS_OFS_KEY, `PFS_KEY1);
    bus(1'b1, `PFS_OFS_KEY, `PFS_KEY2);
    bus(1'b1, `PFS_OFS_CTRL, 8'h26);
    repeat (20) @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    chk("erase_cnt", 32'h2, ners);
    rd(`PFS_OFS_CTRL, 32'h08, "ctrl_rst_wr");
    chk("stall_rst", 32'h0, {31'h0, stall});
    end_of_test();
  end
endmodule : pfs_sequencer_tb
